// ---- verilog/bch_pkg.sv ----
// Shared constants for the block-transfer command port: address decode,
// register indices, field positions and the controller's register map.
// Assumes a 32-bit local bus and one system clock for both ends.
package bch_pkg;

  // Local bus address layout.
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int TOP_LSB = 27;
  localparam logic [4:0] TOP_TAG = 5'h01;
  localparam int BASE_LSB = 24;
  localparam int BASE_W = 3;
  localparam int TAG_LSB = 16;
  localparam logic [7:0] DEST_TAG = 8'h41;
  localparam logic [7:0] REG_TAG = 8'h40;
  localparam int REG_ZERO_LSB = 12;
  localparam logic [3:0] REG_ZERO = 4'h0;
  localparam int WIN_LSB = 22;
  localparam logic [1:0] DATA_WIN = 2'h3;
  localparam int CMD_LSB = 14;
  localparam int COUNT_LSB = 2;
  localparam int COUNT_W = 12;
  localparam int IDX_W = 12;
  localparam logic [1:0] IDX_ZERO = 2'h0;

  // Command codes carried in the destination alias address.
  typedef enum logic [1:0] {
    CMD_SIMPLE = 2'h0,
    CMD_WIDTH = 2'h1,
    CMD_HEIGHT = 2'h2,
    CMD_STORE = 2'h3
  } bch_cmd_t;

  // Engine register indices.
  localparam logic [11:0] IDX_BG = 12'h004;
  localparam logic [11:0] IDX_FG = 12'h008;
  localparam logic [11:0] IDX_SRC = 12'h00c;
  localparam logic [11:0] IDX_WIDTH = 12'h010;
  localparam logic [11:0] IDX_HEIGHT = 12'h014;
  localparam logic [11:0] IDX_RASTER = 12'h018;
  localparam logic [11:0] IDX_SCRATCH = 12'h01c;
  localparam logic [11:0] IDX_STATUS = 12'h020;
  localparam logic [11:0] IDX_DATA = 12'h804;

  // Raster operation control fields.
  localparam int SRC_SEL_LSB = 0;
  localparam int EXPAND_BIT = 2;
  localparam int TRANSP_BIT = 3;
  localparam logic [1:0] SRC_SCREEN = 2'h0;
  localparam logic [1:0] SRC_HOST = 2'h1;
  localparam logic [1:0] SRC_FG = 2'h2;

  // Status register bits.
  localparam int ST_BUSY = 0;
  localparam int ST_QUEUED = 1;
  localparam int ST_EMPTY = 2;
  localparam int ST_FULL = 3;

  localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;
  localparam logic [3:0] BE_FULL = 4'hf;
  localparam int BACKOFF_CYCLES = 128;
  localparam int COORD_W = 16;

  // Controller register map on Avalon-MM (word index = address).
  localparam logic [2:0] AV_ADDR = 3'h0;
  localparam logic [2:0] AV_WDATA = 3'h1;
  localparam logic [2:0] AV_CTRL = 3'h2;
  localparam logic [2:0] AV_STATUS = 3'h3;
  localparam logic [2:0] AV_RDATA = 3'h4;
  localparam int CTRL_START = 0;
  localparam int CTRL_READ = 1;
  localparam int CTRL_BE_LSB = 4;
  localparam int HST_BUSY = 0;
  localparam int HST_DONE = 1;
  localparam int HST_RETRY_LSB = 8;

endpackage

// ---- verilog/bch_bus_if.sv ----
// Local bus between the host CPU end and the drawing engine front end.
// Both ends run on the same system clock; the bench joins them here.
`timescale 1ns/1ns
interface bch_bus_if;
  import bch_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [3:0] be;
  logic wr;
  logic rd;
  logic [DATA_W-1:0] rdata;
  logic ack;
  logic cpu_backoff;
  logic bus_req;

  modport engine (
    input addr, wdata, be, wr, rd, bus_req,
    output rdata, ack, cpu_backoff
  );
  modport cpu (
    output addr, wdata, be, wr, rd, bus_req,
    input rdata, ack, cpu_backoff
  );
endinterface

// ---- verilog/bch_engine_port.sv ----
// Drawing engine front end: address decode, double-buffered geometry,
// command launch, write stalls, host data FIFO and pixel stepping.
// Assumes a CPU that holds each request until ack or cpu_backoff.
// Operation
// - Every destination alias reads the same register
// - Command alias write launches; one alias only stores
// - Decode destination alias at bits 23:16 0x41
// - Code 00: plain transfer, count ignored
// - Code 01: count field gives width
// - Code 10: count field gives height
// - Code 11: store destination, no launch
// - Register update first, then operation starts
// - Raster control selects source, expansion, transparency
// - Software picks host/expand text, foreground fills
// - Height zero draws exactly one row
// - Other registers decoded by word index
// - Reads any width; writes are full words
// - Write while busy stalls the CPU; geometry, destination alias and data port writes are not stalled while busy
// - Status readable validly at any time
// - Geometry registers double buffered for next command
// - After queuing, further writes stall until handover; data port writes stall only on a full FIFO
// - Data port FIFO, aliased in upper window
// - Each operation takes only its data, in order
// - Full FIFO stalls; backoff after 128 cycles
// - Scratch register has no drawing effect
`timescale 1ns/1ns
module bch_engine_port import bch_pkg::*; #(
  parameter int FIFO_DEPTH = 8
) (
  // System
  input wire logic clock,
  input wire logic reset_n,
  // Local bus
  bch_bus_if.engine bus,
  // Configuration
  input wire logic [BASE_W-1:0] engine_base_select,
  // Destination pixel stream
  output logic draw_valid,
  input wire logic draw_ready,
  output logic [COORD_W-1:0] draw_x,
  output logic [COORD_W-1:0] draw_y,
  output logic [DATA_W-1:0] draw_data,
  output logic [DATA_W-1:0] draw_src_origin,
  output logic engine_busy
);

  localparam int PTR_W = $clog2(FIFO_DEPTH);

  initial begin
    if (FIFO_DEPTH < 2 || (1 << PTR_W) != FIFO_DEPTH) begin
      $error("FIFO_DEPTH must be a power of two, at least 2");
    end
  end

  typedef enum logic {ST_IDLE, ST_RUN} bch_state_t;

  bch_state_t state_r;
  logic ack_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] dest_coord_reg, source_coord_reg, act_src_r;
  logic [DATA_W-1:0] bg_r, fg_r, raster_op_control, scratch_r;
  logic [COUNT_W-1:0] width_r, height_r;
  logic launch_pend_r, busy_r;
  logic [7:0] stall_cnt_r;
  logic [COORD_W-1:0] x0_r, cur_x_r, cur_y_r;
  logic [COUNT_W-1:0] act_w_r, x_left_r, y_left_r;
  logic [4:0] bit_r;
  logic [DATA_W-1:0] fifo_mem [FIFO_DEPTH];
  logic [PTR_W:0] wptr_r, rptr_r;

  // Decode.
  logic base_ok, dest_hit, reg_hit, data_hit, req, wr_full;
  logic [IDX_W-1:0] idx;
  bch_cmd_t cmd;
  logic [COUNT_W-1:0] count;
  assign base_ok = bus.addr[ADDR_W-1:TOP_LSB] == TOP_TAG &&
    bus.addr[BASE_LSB+:BASE_W] == engine_base_select;
  assign dest_hit = base_ok && bus.addr[TAG_LSB+:8] == DEST_TAG;
  assign reg_hit = base_ok && bus.addr[TAG_LSB+:8] == REG_TAG &&
    bus.addr[REG_ZERO_LSB+:4] == REG_ZERO;
  assign idx = {bus.addr[IDX_W-1:2], IDX_ZERO};
  assign data_hit = base_ok && (bus.addr[WIN_LSB+:2] == DATA_WIN ||
    (reg_hit && idx == IDX_DATA));
  assign cmd = bch_cmd_t'(bus.addr[CMD_LSB+:2]);
  assign count = bus.addr[COUNT_LSB+:COUNT_W];
  assign req = (bus.wr || bus.rd) && !ack_r;
  // Partial-width writes are taken but change nothing.
  assign wr_full = bus.be == BE_FULL;

  logic geom_wr, launch, fifo_full, fifo_empty, stall, accept;
  assign geom_wr = dest_hit || (reg_hit && (idx == IDX_SRC ||
    idx == IDX_WIDTH || idx == IDX_HEIGHT));
  assign launch = dest_hit && cmd != CMD_STORE;
  assign fifo_full = (wptr_r ^ rptr_r) == {1'b1, {PTR_W{1'b0}}};
  assign fifo_empty = wptr_r == rptr_r;

  always_comb begin
    stall = 1'b0;
    if (bus.wr) begin
      if (data_hit) begin
        stall = fifo_full;
      end else if (launch_pend_r) begin
        stall = 1'b1;
      end else if (!geom_wr) begin
        stall = busy_r;
      end
    end
  end

  assign accept = req && !stall && !bus.cpu_backoff;
  assign bus.ack = ack_r;
  assign bus.rdata = rdata_r;

  // The CPU gets retried only when another master wants the bus.
  assign bus.cpu_backoff = bus.wr && stall && bus.bus_req &&
    stall_cnt_r >= 8'(BACKOFF_CYCLES);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stall_cnt_r <= 8'h00;
    end else if (bus.wr && stall && !bus.cpu_backoff) begin
      if (stall_cnt_r < 8'(BACKOFF_CYCLES)) begin
        stall_cnt_r <= stall_cnt_r + 8'h01;
      end
    end else begin
      stall_cnt_r <= 8'h00;
    end
  end

  // Answer one cycle after acceptance; read data stands with ack.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ack_r <= 1'b0;
      rdata_r <= REG_RESET;
    end else begin
      ack_r <= accept;
      if (accept && bus.rd) begin
        rdata_r <= REG_RESET;
        if (dest_hit) begin
          rdata_r <= dest_coord_reg;
        end else if (reg_hit) begin
          unique case (idx)
            IDX_BG: rdata_r <= bg_r;
            IDX_FG: rdata_r <= fg_r;
            IDX_SRC: rdata_r <= source_coord_reg;
            IDX_WIDTH: rdata_r <= DATA_W'(width_r);
            IDX_HEIGHT: rdata_r <= DATA_W'(height_r);
            IDX_RASTER: rdata_r <= raster_op_control;
            IDX_SCRATCH: rdata_r <= scratch_r;
            IDX_STATUS: rdata_r <= DATA_W'({fifo_full, fifo_empty,
              launch_pend_r, busy_r});
            default: rdata_r <= REG_RESET;
          endcase
        end
      end
    end
  end

  // Pending geometry and plain registers; the write lands before launch.
  logic wr_take;
  assign wr_take = accept && bus.wr && wr_full;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dest_coord_reg <= REG_RESET;
      source_coord_reg <= REG_RESET;
      width_r <= '0;
      height_r <= '0;
      bg_r <= REG_RESET;
      fg_r <= REG_RESET;
      raster_op_control <= REG_RESET;
      scratch_r <= REG_RESET;
    end else if (wr_take && dest_hit) begin
      dest_coord_reg <= bus.wdata;
      if (cmd == CMD_WIDTH) begin
        width_r <= count;
      end
      if (cmd == CMD_HEIGHT) begin
        height_r <= count;
      end
    end else if (wr_take && reg_hit && !data_hit) begin
      unique case (idx)
        IDX_BG: bg_r <= bus.wdata;
        IDX_FG: fg_r <= bus.wdata;
        IDX_SRC: source_coord_reg <= bus.wdata;
        IDX_WIDTH: width_r <= bus.wdata[COUNT_W-1:0];
        IDX_HEIGHT: height_r <= bus.wdata[COUNT_W-1:0];
        IDX_RASTER: raster_op_control <= bus.wdata;
        IDX_SCRATCH: scratch_r <= bus.wdata;
        default: ;
      endcase
    end
  end

  // A launch is held pending until the engine is free to take it.
  logic start;
  assign start = launch_pend_r && state_r == ST_IDLE;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      launch_pend_r <= 1'b0;
    end else if (wr_take && launch) begin
      launch_pend_r <= 1'b1;
    end else if (start) begin
      launch_pend_r <= 1'b0;
    end
  end

  // Pixel stepping.
  logic [1:0] src_sel;
  logic expand, transp, host_src, avail, pix_bit, suppress, step, last_x;
  logic pop;
  assign src_sel = raster_op_control[SRC_SEL_LSB+:2];
  assign expand = raster_op_control[EXPAND_BIT];
  assign transp = raster_op_control[TRANSP_BIT];
  assign host_src = src_sel == SRC_HOST;
  assign avail = state_r == ST_RUN && (!host_src || !fifo_empty);
  assign pix_bit = fifo_mem[rptr_r[PTR_W-1:0]][bit_r];
  assign suppress = host_src && expand && transp && !pix_bit;
  assign step = avail && (draw_ready || suppress);
  assign last_x = x_left_r == '0;
  // Expanded host data uses one word per 32 pixels or per row.
  assign pop = step && host_src &&
    (!expand || bit_r == 5'h1f || last_x);

  assign draw_valid = avail && !suppress;
  assign draw_x = cur_x_r;
  assign draw_y = cur_y_r;
  assign draw_src_origin = act_src_r;
  assign engine_busy = busy_r;

  always_comb begin
    draw_data = fg_r;
    if (host_src) begin
      draw_data = fifo_mem[rptr_r[PTR_W-1:0]];
      if (expand) begin
        draw_data = pix_bit ? fg_r : bg_r;
      end
    end else if (src_sel == SRC_SCREEN) begin
      draw_data = REG_RESET;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      busy_r <= 1'b0;
      act_src_r <= REG_RESET;
      act_w_r <= '0;
      x_left_r <= '0;
      y_left_r <= '0;
      x0_r <= '0;
      cur_x_r <= '0;
      cur_y_r <= '0;
      bit_r <= 5'h00;
    end else if (start) begin
      state_r <= ST_RUN;
      busy_r <= 1'b1;
      act_src_r <= source_coord_reg;
      act_w_r <= width_r;
      x_left_r <= width_r;
      y_left_r <= height_r;
      x0_r <= dest_coord_reg[COORD_W-1:0];
      cur_x_r <= dest_coord_reg[COORD_W-1:0];
      cur_y_r <= dest_coord_reg[DATA_W-1:COORD_W];
      bit_r <= 5'h00;
    end else if (step) begin
      bit_r <= bit_r + 5'h01;
      if (!last_x) begin
        x_left_r <= x_left_r - 1'b1;
        cur_x_r <= cur_x_r + 1'b1;
      end else begin
        bit_r <= 5'h00;
        x_left_r <= act_w_r;
        cur_x_r <= x0_r;
        cur_y_r <= cur_y_r + 1'b1;
        if (y_left_r == '0) begin
          state_r <= ST_IDLE;
          busy_r <= 1'b0;
        end else begin
          y_left_r <= y_left_r - 1'b1;
        end
      end
    end
  end

  // Host data FIFO.
  logic push;
  assign push = wr_take && data_hit;
  always_ff @(posedge clock) begin
    if (push) begin
      fifo_mem[wptr_r[PTR_W-1:0]] <= bus.wdata;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 1'b1;
      end
    end
  end

endmodule

// ---- verilog/bch_cpu_port.sv ----
// Host CPU end: takes orders over Avalon-MM and runs local bus cycles.
// Assumes the engine end acks each request or asks for a backoff retry.
`timescale 1ns/1ns
module bch_cpu_port import bch_pkg::*; (
  // System
  input wire logic clock,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Other bus master wanting the bus
  input wire logic master_request,
  // Local bus
  bch_bus_if.cpu bus
);

  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_BACKOFF} bch_cstate_t;

  bch_cstate_t state_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r, rdata_r, avs_rd_r;
  logic [3:0] be_r;
  logic read_r, done_r, wait_done_r;
  logic [7:0] retry_r;

  // One wait state per access keeps read data registered.
  assign avs_waitrequest = (avs_read || avs_write) && !wait_done_r;
  assign avs_readdata = avs_rd_r;

  // Reads are fetched on the first edge; writes land on the edge at
  // which waitrequest is low, so a master that gives up early has no effect.
  logic take, acc, start;
  assign take = (avs_read || avs_write) && !wait_done_r;
  assign acc = (avs_read || avs_write) && wait_done_r;
  assign start = acc && avs_write && avs_address == AV_CTRL &&
    avs_writedata[CTRL_START] && state_r == ST_IDLE;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wait_done_r <= 1'b0;
      avs_rd_r <= REG_RESET;
    end else begin
      wait_done_r <= take;
      if (take && avs_read) begin
        unique case (avs_address)
          AV_ADDR: avs_rd_r <= addr_r;
          AV_WDATA: avs_rd_r <= wdata_r;
          AV_CTRL: avs_rd_r <= DATA_W'({be_r, 2'h0, read_r, 1'b0});
          AV_STATUS: avs_rd_r <= DATA_W'({retry_r, 6'h00, done_r,
            state_r != ST_IDLE});
          AV_RDATA: avs_rd_r <= rdata_r;
          default: avs_rd_r <= REG_RESET;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      addr_r <= REG_RESET;
      wdata_r <= REG_RESET;
      be_r <= BE_FULL;
      read_r <= 1'b0;
    end else if (acc && avs_write && state_r == ST_IDLE) begin
      if (avs_address == AV_ADDR) begin
        addr_r <= avs_writedata;
      end
      if (avs_address == AV_WDATA) begin
        wdata_r <= avs_writedata;
      end
      if (avs_address == AV_CTRL) begin
        read_r <= avs_writedata[CTRL_READ];
        be_r <= avs_writedata[CTRL_BE_LSB+:4];
      end
    end
  end

  // Bus cycle; a backoff drops the request for a cycle and retries.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      done_r <= 1'b0;
      retry_r <= 8'h00;
      rdata_r <= REG_RESET;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r <= ST_REQ;
            done_r <= 1'b0;
            retry_r <= 8'h00;
          end
        end
        ST_REQ: begin
          if (bus.ack) begin
            state_r <= ST_IDLE;
            done_r <= 1'b1;
            if (read_r) begin
              rdata_r <= bus.rdata;
            end
          end else if (bus.cpu_backoff) begin
            state_r <= ST_BACKOFF;
            retry_r <= retry_r + 8'h01;
          end
        end
        ST_BACKOFF: state_r <= ST_REQ;
      endcase
    end
  end

  // Register writes always go out as full words.
  assign bus.addr = addr_r;
  assign bus.wdata = wdata_r;
  assign bus.be = read_r ? be_r : BE_FULL;
  assign bus.wr = state_r == ST_REQ && !read_r;
  assign bus.rd = state_r == ST_REQ && read_r;
  assign bus.bus_req = master_request;

endmodule

// ---- tb/bch_assertions.sv ----
// Checker for the local bus joining the CPU end and the engine end.
// Assumes one clock domain; it sees only the bus signals.
`timescale 1ns/1ns
module bch_assertions import bch_pkg::*; (
  // System
  input wire logic clock,
  input wire logic reset_n,
  // Local bus
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [3:0] be,
  input wire logic wr,
  input wire logic rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic ack,
  input wire logic cpu_backoff,
  input wire logic bus_req
);
  // The wait is summed over retries, so it never undercounts the stall.
  logic [8:0] stall_r;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stall_r <= 9'h000;
    end else if (ack) begin
      stall_r <= 9'h000;
    end else if (wr && stall_r != 9'h1ff) begin
      stall_r <= stall_r + 9'h001;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence rd_start;
    $rose(rd);
  endsequence
  sequence answer_next;
    ##1 ack;
  endsequence
  wr_rd_excl_a: assert property (!(wr && rd))
    else $error("read and write high together");
  write_full_a: assert property (wr |-> be == BE_FULL)
    else $error("partial write issued");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (ack |-> (wr || rd) && $past(wr || rd))
    else $error("ack without a request");
  read_fast_a: assert property (rd_start |-> answer_next)
    else $error("read not answered next cycle");
  req_hold_a: assert property (wr && !ack && !cpu_backoff |=>
    wr && $stable(addr) && $stable(wdata))
    else $error("stalled write changed");
  backoff_req_a: assert property (cpu_backoff |-> bus_req && wr)
    else $error("backoff without stalled write and request");
  backoff_late_a: assert property (cpu_backoff |-> stall_r >= 9'h07f)
    else $error("backoff before the stall limit");
endmodule

// ---- tb/tb_top.sv ----
// Bench: CPU end and engine end joined by the local bus; Avalon orders in,
// pixel stream out, compared with a queue model of launched commands.
`timescale 1ns/1ns
module tb_top import bch_pkg::*;;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic master_request = 1'b0;
  logic draw_ready = 1'b0;
  logic hold_ready = 1'b0;
  logic draw_valid, engine_busy;
  logic [COORD_W-1:0] draw_x, draw_y;
  logic [DATA_W-1:0] draw_data, draw_src_origin;
  logic [2:0] base = 3'h5;
  logic [31:0] seed = 32'h0001_41e0;
  logic [31:0] fg_val = 32'h0;
  logic [31:0] st;
  int fails = 0;
  int check_count = 0;
  int rem_q[$];
  logic [31:0] src_q[$];
  logic [31:0] data_q[$];
  bit host_q[$];

  bch_bus_if bus ();
  bch_cpu_port u_bch_cpu_port (.clock(clock), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .master_request(master_request),
    .bus(bus.cpu));
  bch_engine_port #(.FIFO_DEPTH(8)) u_bch_engine_port (.clock(clock),
    .reset_n(reset_n), .bus(bus.engine), .engine_base_select(base),
    .draw_valid(draw_valid), .draw_ready(draw_ready), .draw_x(draw_x),
    .draw_y(draw_y), .draw_data(draw_data),
    .draw_src_origin(draw_src_origin), .engine_busy(engine_busy));
  bch_assertions u_bch_assertions (.clock(clock), .reset_n(reset_n),
    .addr(bus.addr), .wdata(bus.wdata), .be(bus.be), .wr(bus.wr),
    .rd(bus.rd), .rdata(bus.rdata), .ack(bus.ack),
    .cpu_backoff(bus.cpu_backoff), .bus_req(bus.bus_req));

  always #50 clock = ~clock;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] ra(input logic [11:0] idx);
    return {TOP_TAG, base, REG_TAG, REG_ZERO, idx};
  endfunction
  function automatic logic [31:0] da(input logic [1:0] c, input logic [11:0] n);
    return {TOP_TAG, base, DEST_TAG, c, n, 2'b00};
  endfunction

  always @(posedge clock) begin
    seed <= lfsr(seed);
    draw_ready <= !hold_ready && seed[0];
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic av(input logic [2:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) fails++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic eng_start(input logic [31:0] a, input logic r,
                           input logic [31:0] d);
    logic [31:0] q;
    av(AV_ADDR, 1'b1, a, q);
    av(AV_WDATA, 1'b1, d, q);
    av(AV_CTRL, 1'b1, {24'h0, BE_FULL, 2'b00, r, 1'b1}, q);
  endtask

  task automatic eng(input logic [31:0] a, input logic r, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    if (a != 32'h0) begin
      eng_start(a, r, d);
    end
    n = 0;
    do begin
      av(AV_STATUS, 1'b0, 32'h0, q);
      n++;
    end while (q[HST_BUSY] !== 1'b0 && n < 2000);
    if (n >= 2000) fails++;
    av(AV_RDATA, 1'b0, 32'h0, q);
  endtask

  task automatic wreg(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] q;
    eng(ra(idx), 1'b0, d, q);
  endtask

  task automatic idle();
    int n;
    n = 0;
    do begin
      eng(ra(IDX_STATUS), 1'b1, 32'h0, st);
      n++;
    end while (st[ST_QUEUED:ST_BUSY] !== 2'b00 && n < 500);
    if (n >= 500) fails++;
  endtask

  task automatic launch(input logic [1:0] c, input logic [11:0] n, input int w,
                        input int h, input logic [31:0] src, input bit host);
    logic [31:0] q;
    wreg(IDX_WIDTH, 32'(w));
    wreg(IDX_HEIGHT, 32'(h));
    wreg(IDX_SRC, src);
    rem_q.push_back(((c == CMD_WIDTH) ? int'(n) + 1 : w + 1) *
                    ((c == CMD_HEIGHT) ? int'(n) + 1 : h + 1));
    src_q.push_back(src);
    host_q.push_back(host);
    eng(da(c, n), 1'b0, seed, q);
  endtask

  always @(posedge clock) begin
    if (reset_n && draw_valid === 1'b1 && draw_ready === 1'b1) begin
      if (rem_q.size() == 0) begin
        check(draw_valid, 1'b0);
      end else begin
        check(draw_src_origin, src_q[0]);
        check(draw_data, host_q[0] ? data_q.pop_front() : fg_val);
        rem_q[0]--;
        if (rem_q[0] == 0) begin
          void'(rem_q.pop_front());
          void'(src_q.pop_front());
          void'(host_q.pop_front());
        end
      end
    end
  end

  initial begin
    repeat (40000) @(posedge clock);
    fails++;
    $display("ERROR at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    logic [31:0] q, v, a;
    int wt[3] = '{6, 6, 2};
    int ht[3] = '{0, 2, 0};
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    v = seed;
    wreg(IDX_SCRATCH, v);
    eng(ra(IDX_SCRATCH + 12'h002), 1'b1, 32'h0, q);
    check(q, v);
    eng(ra(12'h100), 1'b1, 32'h0, q);
    check(q, 32'h0);
    fg_val = seed;
    wreg(IDX_FG, fg_val);
    $display("test registers done");
    v = seed;
    eng(da(CMD_STORE, 12'habc), 1'b0, v, q);
    for (int c = 0; c < 4; c++) begin
      eng(da(2'(c), 12'(c * 7)), 1'b1, 32'h0, q);
      check(q, v);
    end
    $display("test store alias done");
    wreg(IDX_RASTER, 32'(SRC_FG));
    for (int c = 0; c < 3; c++) begin
      launch(2'(c), 12'(9 - 3 * c), wt[c], ht[c], seed, 1'b0);
      idle();
      check(32'(rem_q.size()), 32'h0);
    end
    $display("test command codes done");
    launch(CMD_SIMPLE, 12'h0, 40, 3, seed, 1'b0);
    eng(ra(IDX_STATUS), 1'b1, 32'h0, q);
    check(q[ST_BUSY], 1'b1);
    check(engine_busy, 1'b1);
    launch(CMD_WIDTH, 12'h005, 1, 1, ~seed, 1'b0);
    wreg(IDX_SCRATCH, seed);
    check(32'(rem_q.size() <= 1), 32'h1);
    idle();
    check(32'(rem_q.size()), 32'h0);
    $display("test queued command done");
    hold_ready <= 1'b1;
    wreg(IDX_RASTER, 32'(SRC_HOST));
    launch(CMD_SIMPLE, 12'h0, 8, 0, seed, 1'b1);
    master_request <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      v = seed;
      data_q.push_back(v);
      a = i[0] ? ra(IDX_DATA) : {TOP_TAG, base, DATA_WIN, seed[21:2], 2'b00};
      if (i < 8) begin
        eng(a, 1'b0, v, q);
      end else begin
        eng_start(a, 1'b0, v);
      end
    end
    repeat (300) @(posedge clock);
    av(AV_STATUS, 1'b0, 32'h0, q);
    check(32'(q[HST_RETRY_LSB +: 8] != 8'h00), 32'h1);
    check(32'(rem_q.size()), 32'h1);
    master_request <= 1'b0;
    hold_ready <= 1'b0;
    eng(32'h0, 1'b0, 32'h0, q);
    idle();
    check(32'(rem_q.size() + data_q.size()), 32'h0);
    $display("test data port done");
    finish_test();
  end
endmodule
